// >>> verilog/fp_pkg.sv
// Constants and types for the front-panel indicator and button controller.
// Assumes a single 10 MHz clock; all panel timing counts 1 ms ticks.
package fp_pkg;
    localparam int unsigned CLK_HZ     = 10_000_000;
    localparam int unsigned MS_PER_S   = 1000;
    localparam int unsigned TICK_CYC_DEF = CLK_HZ / MS_PER_S;
    localparam int unsigned MS_W       = 13;
    typedef logic [MS_W-1:0] ms_t;

    localparam int unsigned FLASH_OFF_S   = 2;
    localparam int unsigned SHORT_HOLD_S  = 1;
    localparam int unsigned LONG_HOLD_S   = 4;
    localparam int unsigned REBOOT_DLY_S  = 5;
    localparam ms_t FLASH_ON_MS     = 13'h0064;
    localparam ms_t FLASH_PERIOD_MS = ms_t'(FLASH_OFF_S * MS_PER_S) + FLASH_ON_MS;
    localparam ms_t SHORT_HOLD_MS   = ms_t'(SHORT_HOLD_S * MS_PER_S);
    localparam ms_t LONG_HOLD_MS    = ms_t'(LONG_HOLD_S * MS_PER_S);
    localparam ms_t REBOOT_DLY_MS   = ms_t'(REBOOT_DLY_S * MS_PER_S);
    localparam ms_t BLINK_PERIOD_MS = 13'h01F4;
    localparam ms_t BLINK_ON_MS     = 13'h00FA;
    localparam ms_t HB_PERIOD_MS    = 13'h03E8;
    localparam ms_t HB_PULSE_MS     = 13'h0064;
    localparam ms_t HB_SECOND_MS    = 13'h00C8;
    localparam ms_t DEBOUNCE_MS     = 13'h0014;

    localparam logic [7:0] CTRL_OFF  = 8'h00;
    localparam logic [7:0] CMD_OFF   = 8'h04;
    localparam logic [7:0] EVENT_OFF = 8'h08;
    localparam logic [7:0] STATE_OFF = 8'h0C;

    // Control register fields
    localparam int unsigned CTRL_W      = 14;
    localparam int unsigned C_STAT_LSB  = 0;
    localparam int unsigned C_BOOT_DONE = 3;
    localparam int unsigned C_MEDIA_IN  = 4;
    localparam int unsigned C_UNMOUNTED = 5;
    localparam int unsigned C_LOGGING   = 6;
    localparam int unsigned C_JOB_MEDIA = 7;
    localparam int unsigned C_EJECT_ACQUIRE_BUTTON_ALT  = 9;
    localparam int unsigned C_UPD_MODE  = 10;
    localparam int unsigned C_UPD_LSB   = 11;
    // Command register bits, write-only pulses
    localparam int unsigned K_ERROR     = 0;
    localparam int unsigned K_SCHED     = 1;
    localparam int unsigned K_OFF_ACK   = 2;
    // Event register bits, write one to clear
    localparam int unsigned EV_W        = 7;
    localparam int unsigned E_SHUTDOWN  = 0;
    localparam int unsigned E_REBOOT    = 1;
    localparam int unsigned E_EJECT     = 2;
    localparam int unsigned E_REFUSED   = 3;
    localparam int unsigned E_ACQ_START = 4;
    localparam int unsigned E_ACQ_STOP  = 5;
    localparam int unsigned E_FACTORY   = 6;

    typedef enum logic [1:0] {
        ST_INIT = 2'h0,
        ST_OFF  = 2'h1,
        ST_ON   = 2'h3,
        ST_DOWN = 2'h2
    } pstate_t;

    typedef enum logic [2:0] {
        SM_CONFIG = 3'h0,
        SM_HWDONE = 3'h1,
        SM_WSCHED = 3'h2,
        SM_WJOB   = 3'h3,
        SM_RUN    = 3'h4
    } stat_mode_t;

    typedef enum logic [2:0] {
        UP_START  = 3'h0,
        UP_APPLY  = 3'h1,
        UP_NOFILE = 3'h2,
        UP_OK     = 3'h3,
        UP_FAIL   = 3'h4
    } upd_phase_t;

    // Bicolour LED drive {yellow, green}
    localparam logic [1:0] LED_OFF = 2'h0;
    localparam logic [1:0] LED_GRN = 2'h1;
    localparam logic [1:0] LED_YEL = 2'h2;
endpackage

// >>> verilog/button_debounce.sv
// Synchroniser and debouncer for one active-low panel contact.
// Assumes tick is a one-cycle pulse every millisecond from the same clock.
`timescale 1ns/1ps
`default_nettype none
module button_debounce
    import fp_pkg::*;
(
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic tick,
    input  wire logic raw_n,
    output logic      level,
    output logic      valid
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
        logic vld;
        ms_t  cnt;
    } deb_t;

    deb_t q;
    deb_t n;

    always_comb begin
        n = q;
        n.s1 = ~raw_n;
        n.s2 = q.s1;
        n.s3 = q.s2;
        if (q.s2 != q.s3) begin
            n.cnt = '0;
        end else if (tick && q.cnt != DEBOUNCE_MS) begin
            n.cnt = q.cnt + ms_t'(1);
        end
        // Level only follows a contact that stayed put for the full window
        if (q.cnt == DEBOUNCE_MS) begin
            n.lvl = q.s3;
            n.vld = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign level = q.lvl;
    assign valid = q.vld;
endmodule
`default_nettype wire

// >>> verilog/front_panel_indicator_control.sv
// Front-panel controller: four bicolour LEDs, three buttons, power jumper.
// Assumes the host processor reports its state over APB and polls events.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Power LED: boot yellow, up green, down blinking
// - Status blinks yellow configuring, green when done
// - Awaiting schedule: green 100 ms, 2 s dark
// - Schedule met, job pending: heartbeat blink
// - Job running: status blinks green
// - Error blinks yellow until next schedule start
// - Pending media job: media blinks yellow, eject refused
// - Media LED follows inserted, logging, unmounted, absent
// - Update: all yellow start, power blinks
// - Update status: green applying, yellow no file
// - Update error LED: green then reboot 5 s
// - Jumper fitted, off: brief press powers on
// - Jumper fitted: one second hold shuts down
// - Jumper fitted: four second hold forces off
// - No jumper: always on, one second reboots
// - Eject unmounts media unless media job active
// - Alternate role toggles acquisition start and stop
// - Factory button requests default settings restore
// - Jumper fitted: stay off after power returns
module front_panel_indicator_control
    import fp_pkg::*;
#(
    parameter int unsigned TICK_CYC = TICK_CYC_DEF
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    input  wire logic        power_btn_n,
    input  wire logic        eject_acquire_button_n,
    input  wire logic        factory_btn_n,
    input  wire logic        power_mode_jumper_n,
    output logic [1:0]       power_led,
    output logic [1:0]       status_led,
    output logic [1:0]       error_led,
    output logic [1:0]       media_led,
    output logic             power_en,
    output logic             sys_reboot
);
    typedef struct packed {
        pstate_t            st;
        logic [15:0]        tick_cnt;
        logic               tick;
        ms_t                blink_ms;
        ms_t                hb_ms;
        ms_t                flash_ms;
        ms_t                hold_ms;
        ms_t                upd_ms;
        logic               hold_ok;
        logic               pwr_prev;
        logic               ej_prev;
        logic               fr_prev;
        logic [CTRL_W-1:0]  ctrl;
        logic               err;
        logic [EV_W-1:0]    ev;
        logic               acq;
        logic [1:0]         pled;
        logic [1:0]         sled;
        logic [1:0]         eled;
        logic [1:0]         mled;
        logic               pwr_en;
        logic               reboot;
        logic               rdy;
        logic               slverr;
        logic [31:0]        rdata;
    } state_t;

    state_t q;
    state_t n;

    logic pwr_lvl;
    logic ej_lvl;
    logic fr_lvl;
    logic jmp_lvl;
    logic jmp_vld;

    function automatic ms_t wrap_ms(input ms_t cnt, input ms_t period);
        wrap_ms = (cnt == period - ms_t'(1)) ? '0 : cnt + ms_t'(1);
    endfunction

    function automatic logic [1:0] blink(input logic on, input logic [1:0] colour);
        blink = on ? colour : LED_OFF;
    endfunction

    function automatic logic reg_hit(input logic [7:0] addr);
        reg_hit = (addr == CTRL_OFF) || (addr == CMD_OFF) ||
                  (addr == EVENT_OFF) || (addr == STATE_OFF);
    endfunction

    button_debounce u_pwr (
        .pclk    (pclk),
        .presetn (presetn),
        .tick    (q.tick),
        .raw_n   (power_btn_n),
        .level   (pwr_lvl),
        .valid   ()
    );
    button_debounce u_ej (
        .pclk    (pclk),
        .presetn (presetn),
        .tick    (q.tick),
        .raw_n   (eject_acquire_button_n),
        .level   (ej_lvl),
        .valid   ()
    );
    button_debounce u_fr (
        .pclk    (pclk),
        .presetn (presetn),
        .tick    (q.tick),
        .raw_n   (factory_btn_n),
        .level   (fr_lvl),
        .valid   ()
    );
    button_debounce u_jmp (
        .pclk    (pclk),
        .presetn (presetn),
        .tick    (q.tick),
        .raw_n   (power_mode_jumper_n),
        .level   (jmp_lvl),
        .valid   (jmp_vld)
    );

    always_comb begin
        logic            setup;
        logic            wr_acc;
        logic [EV_W-1:0] ev_set;
        logic [EV_W-1:0] ev_clr;
        logic            cmd_err;
        logic            cmd_sched;
        logic            cmd_ack;
        logic            bl;
        logic            hb;
        logic            fl;
        stat_mode_t      sm;
        upd_phase_t      up;
        setup     = psel && !penable;
        wr_acc    = psel && penable && q.rdy && pwrite;
        ev_set    = '0;
        ev_clr    = '0;
        cmd_err   = 1'b0;
        cmd_sched = 1'b0;
        cmd_ack   = 1'b0;
        bl        = 1'b0;
        hb        = 1'b0;
        fl        = 1'b0;
        sm        = SM_CONFIG;
        up        = UP_START;
        n = q;
        n.tick   = 1'b0;
        n.reboot = 1'b0;

        // One millisecond tick drives every blink and hold timer
        if (q.tick_cnt == 16'(TICK_CYC - 1)) begin
            n.tick_cnt = '0;
            n.tick     = 1'b1;
        end else begin
            n.tick_cnt = q.tick_cnt + 16'h0001;
        end
        if (q.tick) begin
            n.blink_ms = wrap_ms(q.blink_ms, BLINK_PERIOD_MS);
            n.hb_ms    = wrap_ms(q.hb_ms, HB_PERIOD_MS);
            n.flash_ms = wrap_ms(q.flash_ms, FLASH_PERIOD_MS);
        end
        bl = q.blink_ms < BLINK_ON_MS;
        fl = q.flash_ms < FLASH_ON_MS;
        hb = (q.hb_ms < HB_PULSE_MS) ||
             (q.hb_ms >= HB_SECOND_MS && q.hb_ms < HB_SECOND_MS + HB_PULSE_MS);

        // Hold timer only after a release, so the power-on press cannot shut down
        if (!pwr_lvl) begin
            n.hold_ms = '0;
            n.hold_ok = 1'b1;
        end else if (q.tick && q.hold_ms != LONG_HOLD_MS) begin
            n.hold_ms = q.hold_ms + ms_t'(1);
        end
        n.pwr_prev = pwr_lvl;
        n.ej_prev  = ej_lvl;
        n.fr_prev  = fr_lvl;

        // APB: answer registered in setup, data valid through access
        n.rdy    = setup;
        n.slverr = setup && !reg_hit(paddr);
        n.rdata  = '0;
        if (setup && !pwrite) begin
            case (paddr)
                CTRL_OFF:  n.rdata = 32'(q.ctrl);
                EVENT_OFF: n.rdata = 32'(q.ev);
                STATE_OFF: n.rdata = 32'({q.acq, q.err, jmp_lvl, q.st});
                default:   n.rdata = '0;
            endcase
        end
        if (wr_acc) begin
            case (paddr)
                CTRL_OFF:  n.ctrl = pwdata[CTRL_W-1:0];
                CMD_OFF: begin
                    cmd_err   = pwdata[K_ERROR];
                    cmd_sched = pwdata[K_SCHED];
                    cmd_ack   = pwdata[K_OFF_ACK];
                end
                EVENT_OFF: ev_clr = pwdata[EV_W-1:0];
                default:   n.ctrl = q.ctrl;
            endcase
        end
        sm = stat_mode_t'(q.ctrl[C_STAT_LSB +: 3]);
        up = upd_phase_t'(q.ctrl[C_UPD_LSB +: 3]);

        // Error latches regardless of software masking; a new error wins
        n.err = (q.err && !cmd_sched) || cmd_err;

        case (q.st)
            ST_INIT: begin
                if (jmp_vld) begin
                    n.st     = jmp_lvl ? ST_OFF : ST_ON;
                    n.pwr_en = !jmp_lvl;
                end
            end
            ST_OFF: begin
                if (pwr_lvl && !q.pwr_prev) begin
                    n.st      = ST_ON;
                    n.pwr_en  = 1'b1;
                    n.hold_ok = 1'b0;
                end
            end
            ST_ON: begin
                if (q.hold_ok && q.hold_ms >= SHORT_HOLD_MS) begin
                    n.st = ST_DOWN;
                    if (jmp_lvl) begin
                        ev_set[E_SHUTDOWN] = 1'b1;
                    end else begin
                        ev_set[E_REBOOT] = 1'b1;
                    end
                end
            end
            ST_DOWN: begin
                if (cmd_ack) begin
                    n.st     = jmp_lvl ? ST_OFF : ST_ON;
                    n.pwr_en = !jmp_lvl;
                    n.reboot = !jmp_lvl;
                end
            end
            default: n.st = ST_INIT;
        endcase
        // With the jumper fitted, a long hold overrides everything, even a pending orderly shutdown
        if ((q.st == ST_ON || q.st == ST_DOWN) && jmp_lvl &&
            q.hold_ok && q.hold_ms == LONG_HOLD_MS) begin
            n.st     = ST_OFF;
            n.pwr_en = 1'b0;
        end

        if (q.st == ST_ON && ej_lvl && !q.ej_prev) begin
            if (q.ctrl[C_EJECT_ACQUIRE_BUTTON_ALT]) begin
                n.acq = !q.acq;
                ev_set[E_ACQ_START] = !q.acq;
                ev_set[E_ACQ_STOP]  = q.acq;
            end else if (q.ctrl[C_JOB_MEDIA]) begin
                ev_set[E_REFUSED] = 1'b1;
            end else begin
                ev_set[E_EJECT] = 1'b1;
            end
        end
        if (q.st == ST_ON && fr_lvl && !q.fr_prev) begin
            ev_set[E_FACTORY] = 1'b1;
        end

        // Successful update reboots itself after the settle delay
        if (q.st == ST_ON && q.ctrl[C_UPD_MODE] && up == UP_OK) begin
            if (q.tick && q.upd_ms != REBOOT_DLY_MS) begin
                n.upd_ms = q.upd_ms + ms_t'(1);
                if (q.upd_ms == REBOOT_DLY_MS - ms_t'(1)) begin
                    n.reboot = 1'b1;
                    ev_set[E_REBOOT] = 1'b1;
                end
            end
        end else begin
            n.upd_ms = '0;
        end
        // A set in the same cycle as its clear survives
        n.ev = (q.ev & ~ev_clr) | ev_set;

        n.pled = LED_OFF;
        n.sled = LED_OFF;
        n.eled = LED_OFF;
        n.mled = LED_OFF;
        if (q.st == ST_ON || q.st == ST_DOWN) begin
            if (q.ctrl[C_UPD_MODE]) begin
                if (up == UP_START) begin
                    n.pled = LED_YEL;
                    n.sled = LED_YEL;
                    n.eled = LED_YEL;
                    n.mled = LED_YEL;
                end else begin
                    n.pled = blink(bl, LED_YEL);
                    case (up)
                        UP_APPLY:  n.sled = blink(bl, LED_GRN);
                        UP_NOFILE: n.sled = blink(bl, LED_YEL);
                        UP_OK:     n.eled = blink(bl, LED_GRN);
                        UP_FAIL:   n.eled = blink(bl, LED_YEL);
                        default:   n.sled = LED_OFF;
                    endcase
                end
            end else begin
                if (q.st == ST_DOWN) begin
                    n.pled = blink(bl, LED_YEL);
                end else begin
                    n.pled = q.ctrl[C_BOOT_DONE] ? LED_GRN : LED_YEL;
                end
                case (sm)
                    SM_CONFIG: n.sled = blink(bl, LED_YEL);
                    SM_HWDONE: n.sled = LED_GRN;
                    SM_WSCHED: n.sled = blink(fl, LED_GRN);
                    SM_WJOB:   n.sled = blink(hb, LED_GRN);
                    SM_RUN:    n.sled = blink(bl, LED_GRN);
                    default:   n.sled = LED_OFF;
                endcase
                n.eled = blink(bl && q.err, LED_YEL);
                if (q.ctrl[C_JOB_MEDIA] && !q.ctrl[C_LOGGING]) begin
                    n.mled = blink(bl, LED_YEL);
                end else if (!q.ctrl[C_MEDIA_IN]) begin
                    n.mled = LED_OFF;
                end else if (q.ctrl[C_LOGGING]) begin
                    n.mled = blink(bl, LED_GRN);
                end else if (q.ctrl[C_UNMOUNTED]) begin
                    n.mled = LED_GRN;
                end else begin
                    n.mled = LED_YEL;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign pready     = q.rdy;
    assign prdata     = q.rdata;
    assign pslverr    = q.slverr;
    assign power_led  = q.pled;
    assign status_led = q.sled;
    assign error_led  = q.eled;
    assign media_led  = q.mled;
    assign power_en   = q.pwr_en;
    assign sys_reboot = q.reboot;

    off_dark_a: assert property (@(posedge pclk) disable iff (!presetn)
        (q.st == ST_OFF) |=> (power_led == LED_OFF && status_led == LED_OFF))
        else $error("panel lit while device off");

    down_blink_a: assert property (@(posedge pclk) disable iff (!presetn)
        (q.st == ST_DOWN && !q.ctrl[C_UPD_MODE]) |=> (power_led != LED_GRN))
        else $error("power LED green while going down");

    force_off_a: assert property (@(posedge pclk) disable iff (!presetn)
        ((q.st == ST_ON || q.st == ST_DOWN) && jmp_lvl && q.hold_ok && q.hold_ms == LONG_HOLD_MS)
        |=> (q.st == ST_OFF) ##1 !power_en)
        else $error("long hold did not force power off");

    eject_refuse_a: assert property (@(posedge pclk) disable iff (!presetn)
        (q.st == ST_ON && ej_lvl && !q.ej_prev && !q.ctrl[C_EJECT_ACQUIRE_BUTTON_ALT] && q.ctrl[C_JOB_MEDIA])
        |=> (q.ev[E_REFUSED] && $stable(q.ev[E_EJECT])))
        else $error("eject not refused during media job");

    err_set_a: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && pready && pwrite && paddr == CMD_OFF && pwdata[K_ERROR])
        |=> q.err)
        else $error("error event lost");

    stay_off_a: assert property (@(posedge pclk) disable iff (!presetn)
        (q.st == ST_INIT && jmp_vld && jmp_lvl) |=> (q.st == ST_OFF && !power_en))
        else $error("device came back on after power loss");

    flash_dark_a: assert property (@(posedge pclk) disable iff (!presetn)
        (q.st == ST_ON && !q.ctrl[C_UPD_MODE] && q.ctrl[C_STAT_LSB +: 3] == SM_WSCHED &&
         q.flash_ms >= FLASH_ON_MS) |=> (status_led == LED_OFF))
        else $error("flash pattern lit in dark phase");

    media_dark_a: assert property (@(posedge pclk) disable iff (!presetn)
        (!q.ctrl[C_MEDIA_IN] && !q.ctrl[C_JOB_MEDIA] && !q.ctrl[C_UPD_MODE]) |=> (media_led == LED_OFF))
        else $error("media LED lit with no media");

    upd_reboot_a: assert property (@(posedge pclk) disable iff (!presetn)
        (sys_reboot && q.st == ST_ON && q.ctrl[C_UPD_MODE]) |-> $past(q.upd_ms) == REBOOT_DLY_MS - ms_t'(1))
        else $error("update reboot at wrong delay");
endmodule
`default_nettype wire

// >>> bench/panel_operator.sv
// Operator at the panel: presses the three buttons and sets the power jumper.
// Assumes pclk from the bench and TICK_CYC clocks per panel millisecond.
`timescale 1ns/1ps
`default_nettype none
module panel_operator #(
    parameter int TICK_CYC = 2
) (
    input  wire logic pclk,
    output logic      power_btn_n,
    output logic      eject_acquire_button_n,
    output logic      factory_btn_n,
    output logic      power_mode_jumper_n
);
    // Released contacts read high through the panel pull-ups
    initial begin
        power_btn_n = 1'b1;
        eject_acquire_button_n = 1'b1;
        factory_btn_n = 1'b1;
        power_mode_jumper_n = 1'b0;
    end
    task automatic set_jumper(input logic n);
        power_mode_jumper_n <= n;
    endtask
    task automatic press(input int b, input int ms);
        case (b)
            0: power_btn_n <= 1'b0;
            1: eject_acquire_button_n <= 1'b0;
            default: factory_btn_n <= 1'b0;
        endcase
        repeat (ms * TICK_CYC) @(posedge pclk);
        power_btn_n <= 1'b1;
        eject_acquire_button_n <= 1'b1;
        factory_btn_n <= 1'b1;
    endtask
endmodule
`default_nettype wire

// >>> bench/front_panel_indicator_control_tb.sv
// Self-checking bench for the front-panel controller.
// Assumes TICK_CYC of 2, so one panel millisecond lasts two clocks.
`timescale 1ns/1ps
`default_nettype none
module front_panel_indicator_control_tb;
    import fp_pkg::*;
    localparam int T = 2;
    localparam logic [3:0] SMK [5] = '{4'h5, 4'h2, 4'h3, 4'h3, 4'h3};
    localparam int         LO  [5] = '{0, 0, 100, 400, 1000};
    localparam logic [31:0] MC [5] = '{32'h10, 32'h50, 32'h30, 32'h0, 32'h90};
    localparam logic [3:0] MM  [5] = '{4'h4, 4'h3, 4'h2, 4'h1, 4'h5};
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, power_en, sys_reboot, e;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rv;
    logic [1:0]  power_led, status_led, error_led, media_led;
    logic [3:0]  m [4];
    wire logic   pb_n, ej_n, fb_n, jp_n;
    int          errors, tests_run, lit, n;

    front_panel_indicator_control #(.TICK_CYC(T)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .power_btn_n(pb_n), .eject_acquire_button_n(ej_n),
        .factory_btn_n(fb_n), .power_mode_jumper_n(jp_n), .power_led(power_led),
        .status_led(status_led), .error_led(error_led), .media_led(media_led),
        .power_en(power_en), .sys_reboot(sys_reboot));
    panel_operator #(.TICK_CYC(T)) op (.pclk(pclk), .power_btn_n(pb_n),
        .eject_acquire_button_n(ej_n), .factory_btn_n(fb_n), .power_mode_jumper_n(jp_n));

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    task automatic stop_test();
        if (errors == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        tests_run++;
        if (g !== x) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, x, g);
        end
    endtask
    // Extra edge at the end keeps back-to-back calls from driving psel twice in one step
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rv = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(nm, x, rv);
    endtask
    task automatic watch(input int ms);
        m = '{default: 4'h0};
        lit = 0;
        repeat (ms * T) begin
            @(posedge pclk);
            m[0] |= 4'h1 << power_led;
            m[1] |= 4'h1 << status_led;
            m[2] |= 4'h1 << error_led;
            m[3] |= 4'h1 << media_led;
            lit += int'(status_led != 2'h0);
        end
    endtask
    task automatic push(input int b);
        op.press(b, 40);
        repeat (40 * T) @(posedge pclk);
    endtask
    task automatic wait_reboot(input int lim);
        n = 0;
        while (sys_reboot !== 1'b1 && n < lim) begin
            @(posedge pclk);
            n++;
        end
    endtask
    task automatic do_reset();
        presetn <= 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        repeat (40 * T) @(posedge pclk);
    endtask

    initial begin
        repeat (90000) @(posedge pclk);
        errors++;
        stop_test();
    end

    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        errors = 0;
        tests_run = 0;
        do_reset();
        rd("unmapped", 8'h10, 32'h0);
        chk("pslverr", 32'h1, 32'(e));
        rd("state", STATE_OFF, 32'h5);
        watch(40);
        chk("leds", 32'h1111, {16'h0, m[0], m[1], m[2], m[3]});
        op.press(0, 5);
        repeat (40 * T) @(posedge pclk);
        chk("glitch", 32'h0, 32'(power_en));
        push(0);
        chk("power_en", 32'h1, 32'(power_en));
        watch(20);
        chk("boot", 32'h4, 32'(m[0]));
        for (int i = 0; i < 5; i++) begin
            wr(CTRL_OFF, 32'(i) | 32'h8);
            watch(2200);
            chk("power", 32'h2, 32'(m[0]));
            chk("status", 32'(SMK[i]), 32'(m[1]));
            if (i > 1) chk("lit", 32'h1, 32'(lit >= (LO[i] - 1) * T && lit <= (LO[i] + 201) * T));
        end
        wr(CMD_OFF, 32'h1);
        watch(600);
        chk("error", 32'h5, 32'(m[2]));
        wr(CMD_OFF, 32'h2);
        watch(600);
        chk("error", 32'h1, 32'(m[2]));
        for (int i = 0; i < 5; i++) begin
            wr(CTRL_OFF, 32'h9 | MC[i]);
            watch(600);
            chk("media", 32'(MM[i]), 32'(m[3]));
        end
        push(1);
        rd("event", EVENT_OFF, 32'h8);
        wr(EVENT_OFF, 32'h7F);
        wr(CTRL_OFF, 32'h19);
        push(1);
        rd("event", EVENT_OFF, 32'h4);
        wr(EVENT_OFF, 32'h7F);
        wr(CTRL_OFF, 32'h209);
        push(1);
        rd("state", STATE_OFF, 32'h17);
        push(1);
        rd("event", EVENT_OFF, 32'h30);
        wr(EVENT_OFF, 32'h7F);
        push(2);
        rd("event", EVENT_OFF, 32'h40);
        wr(EVENT_OFF, 32'h7F);
        wr(CTRL_OFF, 32'h408);
        watch(600);
        chk("upd", 32'h4444, {16'h0, m[0], m[1], m[2], m[3]});
        wr(CTRL_OFF, 32'hC08);
        watch(600);
        chk("upd", 32'h53, {24'h0, m[0], m[1]});
        wr(CTRL_OFF, 32'h1408);
        watch(600);
        chk("upd", 32'h5, 32'(m[1]));
        wr(CTRL_OFF, 32'h2408);
        watch(600);
        chk("upd", 32'h5, 32'(m[2]));
        wr(CTRL_OFF, 32'h1C08);
        watch(600);
        chk("upd", 32'h3, 32'(m[2]));
        wait_reboot(5000 * T);
        chk("delay", 32'h1, 32'(n + 600 * T >= 4990 * T && n + 600 * T <= 5010 * T));
        rd("event", EVENT_OFF, 32'h2);
        wr(EVENT_OFF, 32'h7F);
        wr(CTRL_OFF, 32'h8);
        op.press(0, 1200);
        rd("state", STATE_OFF, 32'h6);
        watch(600);
        chk("down", 32'h5, 32'(m[0]));
        rd("event", EVENT_OFF, 32'h1);
        wr(EVENT_OFF, 32'h7F);
        wr(CMD_OFF, 32'h4);
        rd("state", STATE_OFF, 32'h5);
        push(0);
        op.press(0, 4200);
        chk("power_en", 32'h0, 32'(power_en));
        rd("state", STATE_OFF, 32'h5);
        op.set_jumper(1'b1);
        do_reset();
        rd("state", STATE_OFF, 32'h3);
        chk("power_en", 32'h1, 32'(power_en));
        op.press(0, 1200);
        rd("event", EVENT_OFF, 32'h2);
        watch(600);
        chk("down", 32'h5, 32'(m[0]));
        fork
            wr(CMD_OFF, 32'h4);
            wait_reboot(100);
        join
        chk("reboot", 32'h1, 32'(n < 100));
        rd("state", STATE_OFF, 32'h3);
        stop_test();
    end
endmodule
`default_nettype wire
